// File: design/flash_host_pkg.sv
package flash_host_pkg;
  // command codes written on the data bus
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
  localparam logic [7:0] CMD_PAGE_PROG = 8'hE8;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_SET = 8'h01;
  localparam logic [7:0] CMD_LOCKDOWN_SET = 8'h2F;
  localparam logic [7:0] CMD_PART_CFG = 8'h04;
  localparam logic [7:0] CMD_OTP_PROG = 8'hC0;
  // identifier area offsets
  localparam logic [15:0] ID_MFR_OFS = 16'h0000;
  localparam logic [15:0] ID_DEV_OFS = 16'h0001;
  localparam logic [15:0] ID_LOCK_OFS = 16'h0002;
  localparam logic [15:0] ID_PCR_OFS = 16'h0006;
  localparam int PCR_FIELD_LSB = 8;
  localparam logic [5:0] PART_STEP = 6'h10;
  localparam logic [1:0] LOCK_BITS_MASK = 2'h3;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  // bus phase timing in clock cycles (20 ns each)
  localparam int SETUP_CYC = 2;
  localparam int STROBE_CYC = 4;
  localparam int HOLD_CYC = 2;
  localparam int PAGE_WORDS_MAX = 32;

  // user-side operations
  typedef enum logic [3:0] {
    OP_READ_ARRAY = 4'h0, OP_READ_ID = 4'h1, OP_QUERY = 4'h2, OP_STATUS = 4'h3,
    OP_CLR_STATUS = 4'h4, OP_BLOCK_ERASE = 4'h5, OP_CHIP_ERASE = 4'h6,
    OP_PROGRAM = 4'h7, OP_PAGE_PROG = 4'h8, OP_SUSPEND = 4'h9, OP_RESUME = 4'hA,
    OP_LOCK_SET = 4'hB, OP_LOCK_CLEAR = 4'hC, OP_LOCKDOWN = 4'hD,
    OP_PART_CFG = 4'hE, OP_OTP_PROG = 4'hF
  } op_e;

  typedef struct packed {
    op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [5:0] count;
    logic do_read;
  } request_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic [ADDR_W-1:0] addr;
  } flash_ctl_s;

  // id area partition base legal for a given configuration field
  function automatic logic part_base_ok(input logic [2:0] cfg, input logic [1:0] part);
    part_base_ok = (part == 2'h0) || cfg[part - 2'h1];
  endfunction : part_base_ok
endpackage : flash_host_pkg

// File: design/flash_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int PAGE_MAX = PAGE_WORDS_MAX
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // user request
  input wire logic req_valid_in,
  input wire request_s req_in,
  output logic req_ready_out,
  input wire logic [DATA_W-1:0] page_data_in,
  output logic page_data_take_out,
  input wire logic supply_low_in,
  input wire logic [2:0] part_cfg_in,
  // user answer
  output logic done_out,
  output logic refused_out,
  output logic [DATA_W-1:0] rdata_out,
  // flash pins
  output flash_ctl_s flash_ctl_out,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n_out
);
  if (PAGE_MAX < 1 || PAGE_MAX > 64) begin : g_page_max_check
    $error("PAGE_MAX out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_STROBE = 3'b011, ST_HOLD = 3'b010,
    ST_NEXT = 3'b110, ST_DONE = 3'b111
  } state_e;

  state_e state, next_state;
  request_s req, next_req;
  logic [2:0] step, next_step;     // bus cycle index within the operation
  logic [6:0] words, next_words;   // page words still to load
  logic [3:0] tmr, next_tmr;
  logic is_read, next_is_read;
  logic [DATA_W-1:0] wdata, next_wdata;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic done, next_done, refused, next_refused;

  function automatic logic alters(input op_e op);
    alters = op inside {OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_PROGRAM, OP_PAGE_PROG,
                        OP_OTP_PROG, OP_LOCK_SET, OP_LOCK_CLEAR, OP_LOCKDOWN, OP_PART_CFG};
  endfunction : alters

  // cycle table: data and address of the bus cycle about to start, and whether it is a read
  // built from next-state terms so the first cycle uses the request being taken
  always_comb begin
    logic [7:0] c1;
    logic [7:0] c2;
    logic [ADDR_W-1:0] a;
    c1 = CMD_READ_ARRAY;
    c2 = CMD_CONFIRM;
    a = next_req.addr;
    unique case (next_req.op)
      OP_READ_ARRAY: c1 = CMD_READ_ARRAY;
      OP_READ_ID: c1 = CMD_READ_ID;
      OP_QUERY: c1 = CMD_QUERY;
      OP_STATUS: c1 = CMD_STATUS;
      OP_CLR_STATUS: c1 = CMD_CLR_STATUS;
      OP_BLOCK_ERASE: c1 = CMD_BLOCK_ERASE;
      OP_CHIP_ERASE: c1 = CMD_CHIP_ERASE;
      OP_PROGRAM: c1 = CMD_PROGRAM;
      OP_PAGE_PROG: begin
        c1 = CMD_PAGE_PROG;
        c2 = {2'h0, next_req.count};
      end
      OP_SUSPEND: c1 = CMD_SUSPEND;
      OP_RESUME: c1 = CMD_CONFIRM;
      OP_LOCK_SET: begin
        c1 = CMD_LOCK_SETUP;
        c2 = CMD_LOCK_SET;
      end
      OP_LOCK_CLEAR: c1 = CMD_LOCK_SETUP;
      OP_LOCKDOWN: begin
        c1 = CMD_LOCK_SETUP;
        c2 = CMD_LOCKDOWN_SET;
      end
      OP_PART_CFG: begin
        c1 = CMD_LOCK_SETUP;
        c2 = CMD_PART_CFG;
        a = {next_req.addr[ADDR_W-1:DATA_W], next_req.data};
      end
      OP_OTP_PROG: c1 = CMD_OTP_PROG;
    endcase
    next_addr = a;
    next_is_read = 1'b0;
    if (next_step == 3'h0) begin
      next_wdata = {8'h00, c1};
    end else if (next_req.op inside {OP_PROGRAM, OP_OTP_PROG}) begin
      next_wdata = next_req.data;
    end else if (next_req.op == OP_PAGE_PROG && next_step == 3'h2) begin
      next_wdata = page_data_in;
      next_addr = a + ADDR_W'(next_req.count - 6'(next_words - 7'h1));
    end else if (next_req.op == OP_PAGE_PROG && next_step == 3'h3) begin
      next_wdata = {8'h00, CMD_CONFIRM};
    end else if (next_req.op inside {OP_READ_ID, OP_QUERY, OP_STATUS, OP_READ_ARRAY}) begin
      next_wdata = '0;
      next_is_read = 1'b1;
    end else begin
      next_wdata = {8'h00, c2};
    end
  end

  logic two_cycle, page_more;
  assign two_cycle = req.op inside {OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_PROGRAM,
                     OP_PAGE_PROG, OP_LOCK_SET, OP_LOCK_CLEAR, OP_LOCKDOWN,
                     OP_PART_CFG, OP_OTP_PROG} || req.do_read;
  assign page_more = req.op == OP_PAGE_PROG && step >= 3'h1 && step <= 3'h2;

  logic id_ok;
  assign id_ok = req_in.op != OP_READ_ID || !req_in.do_read ||
                 part_base_ok(part_cfg_in, req_in.addr[21:20]);

  // sequencer
  always_comb begin
    next_state = state;
    next_req = req;
    next_step = step;
    next_words = words;
    next_tmr = tmr;
    next_rdata = rdata;
    next_done = 1'b0;
    next_refused = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_step = 3'h0;
        next_tmr = 4'(SETUP_CYC - 1);
        if (req_valid_in) begin
          if ((supply_low_in && alters(req_in.op)) || !id_ok) begin
            next_refused = 1'b1;
          end else begin
            next_req = req_in;
            next_words = 7'(req_in.count) + 7'h1;
            next_state = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        next_tmr = tmr - 4'h1;
        if (tmr == 4'h0) begin
          next_tmr = 4'(STROBE_CYC - 1);
          next_state = ST_STROBE;
        end
      end
      ST_STROBE: begin
        next_tmr = tmr - 4'h1;
        if (tmr == 4'h0) begin
          next_tmr = 4'(HOLD_CYC - 1);
          if (is_read) next_rdata = dq_in;
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        next_tmr = tmr - 4'h1;
        if (tmr == 4'h0) next_state = ST_NEXT;
      end
      ST_NEXT: begin
        next_tmr = 4'(SETUP_CYC - 1);
        next_state = ST_SETUP;
        if (req.op == OP_PAGE_PROG && step == 3'h2 && words > 7'h1) begin
          next_words = words - 7'h1;
        end else if (step == 3'h0 && !two_cycle) begin
          next_state = ST_DONE;
        end else if (step != 3'h0 && !page_more) begin
          next_state = ST_DONE;
        end else begin
          next_step = step + 3'h1;
        end
      end
      ST_DONE: begin
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  logic [DATA_W-1:0] wdata_q;
  logic [ADDR_W-1:0] addr_q;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      req <= '0;
      step <= 3'h0;
      words <= 7'h0;
      tmr <= 4'h0;
      is_read <= 1'b0;
      wdata_q <= '0;
      addr_q <= '0;
      rdata <= '0;
      done <= 1'b0;
      refused <= 1'b0;
    end else begin
      state <= next_state;
      req <= next_req;
      step <= next_step;
      words <= next_words;
      tmr <= next_tmr;
      rdata <= next_rdata;
      done <= next_done;
      refused <= next_refused;
      if (state == ST_NEXT || state == ST_IDLE) begin
        is_read <= next_is_read;
        wdata_q <= next_wdata;
        addr_q <= next_addr;
      end
    end
  end
  assign wdata = wdata_q;

  // strobes: one of oe/we only, and we rises before data and address change
  always_comb begin
    flash_ctl_out.rst_n = rst_n_in;
    flash_ctl_out.addr = addr_q;
    flash_ctl_out.ce_n = !(state inside {ST_SETUP, ST_STROBE, ST_HOLD});
    flash_ctl_out.oe_n = !(state == ST_STROBE && is_read);
    flash_ctl_out.we_n = !(state == ST_STROBE && !is_read);
  end
  assign dq_out = wdata;
  assign dq_oe_n_out = is_read || flash_ctl_out.ce_n;
  assign req_ready_out = state == ST_IDLE;
  assign page_data_take_out = state == ST_NEXT && page_more
                              && !(step == 3'h2 && words == 7'h1);
  assign done_out = done;
  assign refused_out = refused;
  assign rdata_out = rdata;

  strobe_excl_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !(!flash_ctl_out.oe_n && !flash_ctl_out.we_n)) else $error("oe and we both low");
  bus_release_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !flash_ctl_out.oe_n |-> dq_oe_n_out) else $error("host drives during read");
  lockout_refuse_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state == ST_IDLE && req_valid_in && supply_low_in && alters(req_in.op))
    |=> refused_out && state == ST_IDLE) else $error("alter op not refused");
  we_width_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $fell(flash_ctl_out.we_n) |-> !flash_ctl_out.we_n [*4] ##1 flash_ctl_out.we_n)
    else $error("write strobe width wrong");
  addr_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !flash_ctl_out.we_n |=> $stable(flash_ctl_out.addr) && $stable(dq_out))
    else $error("data moved at strobe rise");
  cmd_ff_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ($fell(flash_ctl_out.we_n) && req.op == OP_READ_ARRAY) |-> dq_out[7:0] == 8'hFF)
    else $error("read array code wrong");
  same_addr_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ($fell(flash_ctl_out.we_n) && step == 3'h1 && req.op != OP_PAGE_PROG)
    |-> flash_ctl_out.addr[15:0] == next_addr[15:0]) else $error("second address differs");
  done_bound_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state == ST_IDLE && req_valid_in && req_ready_out && !refused_out && req_in.op == OP_SUSPEND
     && !supply_low_in) |-> ##[8:12] done_out) else $error("single cycle not done");
endmodule : flash_host_ctrl
`default_nettype wire

// File: testbench/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [15:0] MFR_CODE = 16'h1234, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h5678, // arbitrary value
  parameter logic [15:0] QRY_WORD = 16'h5151,
  parameter logic [15:0] STS_INIT = 16'h00F8
) (
  // host side
  input wire flash_ctl_s ctl_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out
);
  logic [7:0] mode = 8'hFF;
  logic [7:0] prev = 8'h00;
  logic [1:0] id_part = 2'h0;
  logic [15:0] sts = STS_INIT;
  logic [15:0] partition_config_reg = 16'h0000;
  logic [15:0] rd;
  logic [15:0] last = 16'h0000;
  always @(posedge ctl_in.we_n) begin
    if (ctl_in.rst_n && !ctl_in.ce_n) begin
      // two-cycle codes other than the 60/04 partition config pair are simply accepted
      if (dq_in[7:0] inside {8'hFF, 8'h90, 8'h98, 8'h70}) mode <= dq_in[7:0];
      if (dq_in[7:0] == 8'h90) id_part <= ctl_in.addr[21:20];
      if (dq_in[7:0] == 8'h50) sts <= sts & 16'hFFCF;
      if (prev == 8'h60 && dq_in[7:0] == 8'h04) partition_config_reg <= ctl_in.addr[15:0];
      prev <= dq_in[7:0];
    end
  end
  always_comb begin
    rd = ctl_in.addr[15:0] ^ 16'hA5A5;
    if (mode == 8'h70) rd = sts;
    if (mode == 8'h98) rd = QRY_WORD;
    if (mode == 8'h90 && ctl_in.addr[21:20] == id_part) begin
      if (ctl_in.addr[15:0] == 16'h0000) rd = MFR_CODE;
      if (ctl_in.addr[15:0] == 16'h0001) rd = DEV_CODE;
      if (ctl_in.addr[14:0] == 15'h0002) rd = 16'h0001;
      if (ctl_in.addr[15:0] == 16'h0006) rd = partition_config_reg;
    end
  end
  // a released bus shows the inverse of the last word driven
  always @(posedge ctl_in.oe_n) last <= rd;
  assign dq_out = (ctl_in.rst_n && !ctl_in.ce_n && !ctl_in.oe_n) ? rd : ~last;
endmodule : flash_dev_model
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import flash_host_pkg::*;
;
  localparam logic [15:0] MFR = 16'h1234; // arbitrary value
  localparam logic [15:0] DEV = 16'h5678; // arbitrary value
  localparam logic [15:0] QRY = 16'h5151;
  localparam logic [15:0] CODES [16] = '{16'hFF00, 16'h9000, 16'h9800, 16'h7000,
    16'h5000, 16'h20D0, 16'h30D0, 16'h4000, 16'hE800, 16'hB000, 16'hD000, 16'h6001,
    16'h60D0, 16'h602F, 16'h6004, 16'hC000};
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic supply_low_in = 1'b0;
  logic [2:0] part_cfg_in = 3'h7;
  request_s req_in = '0;
  logic req_ready_out, page_data_take_out, done_out, refused_out, dq_oe_n_out;
  logic [DATA_W-1:0] page_data_in = '0;
  logic [DATA_W-1:0] rdata_out, dq_out, dev_dq, bus;
  logic [DATA_W-1:0] last_rd = '0;
  logic [DATA_W-1:0] sts = 16'h00F8;
  logic [DATA_W-1:0] partition_config_reg = '0;
  flash_ctl_s ctl;
  int miscompares = 0;
  int tests_run = 0;
  logic [DATA_W-1:0] pg [$];
  logic [DATA_W:0] exp_res [$];
  logic [ADDR_W+DATA_W-1:0] exp_wr [$];
  always #10 core_clk_in = ~core_clk_in;
  assign bus = dq_oe_n_out ? dev_dq : dq_out;
  flash_host_ctrl #(.PAGE_MAX(8)) uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
    .page_data_in(page_data_in), .page_data_take_out(page_data_take_out),
    .supply_low_in(supply_low_in), .part_cfg_in(part_cfg_in), .done_out(done_out),
    .refused_out(refused_out), .rdata_out(rdata_out), .flash_ctl_out(ctl), .dq_in(bus),
    .dq_out(dq_out), .dq_oe_n_out(dq_oe_n_out));
  flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .QRY_WORD(QRY)) dev (.ctl_in(ctl),
    .dq_in(bus), .dq_out(dev_dq));
  task automatic chk_val(input string nm, input logic [DATA_W:0] e, input logic [DATA_W:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk_val
  task automatic chk_wr(input logic [37:0] e, input logic [37:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH bus_write exp %h got %h", e, g);
    end
  endtask : chk_wr
  task automatic finish_test();
    if (miscompares == 0 && tests_run > 0 && exp_wr.size() == 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic do_op(input op_e op, input logic [21:0] a, input logic [15:0] d,
      input logic [5:0] n, input logic rd);
    logic re;
    logic [21:0] wa;
    logic [15:0] w;
    int k;
    re = (supply_low_in && op inside {OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_PROGRAM,
      OP_PAGE_PROG, OP_OTP_PROG, OP_LOCK_SET, OP_LOCK_CLEAR, OP_LOCKDOWN, OP_PART_CFG}) ||
      (op == OP_READ_ID && a[21:20] != 2'h0 && !part_cfg_in[a[21:20] - 2'h1]);
    wa = (op == OP_PART_CFG) ? {a[21:16], d} : a;
    if (!re) begin
      exp_wr.push_back({wa, 8'h00, CODES[op][15:8]});
      if (op == OP_PROGRAM || op == OP_OTP_PROG) exp_wr.push_back({a, d});
      if (op == OP_PAGE_PROG) begin
        exp_wr.push_back({a, 10'h000, n});
        for (k = 0; k <= int'(n); k++) begin
          w = 16'($urandom);
          pg.push_back(w);
          exp_wr.push_back({a + 22'(k), w});
        end
        exp_wr.push_back({a, 16'h00D0});
        page_data_in = pg.pop_front();
      end else if (CODES[op][7:0] != 8'h00) exp_wr.push_back({wa, 8'h00, CODES[op][7:0]});
      if (op == OP_CLR_STATUS) sts = sts & 16'hFFCF;
      if (op == OP_PART_CFG) partition_config_reg = d;
      if (rd) case (op)
        OP_READ_ARRAY: last_rd = a[15:0] ^ 16'hA5A5;
        OP_QUERY: last_rd = QRY;
        OP_STATUS: last_rd = sts;
        OP_READ_ID: last_rd = a[15:0] == 16'h0000 ? MFR : a[15:0] == 16'h0001 ? DEV :
          a[14:0] == 15'h0002 ? 16'h0001 : partition_config_reg;
        default: ;
      endcase
    end
    exp_res.push_back({re, last_rd});
    @(posedge core_clk_in) #1;
    chk_val("ready", 17'h1, {16'h0000, req_ready_out});
    req_in = '{op, a, d, n, rd};
    req_valid_in = 1'b1;
    @(posedge core_clk_in) #1;
    req_valid_in = 1'b0;
    for (k = 0; k < 900 && done_out !== 1'b1 && refused_out !== 1'b1; k++)
      @(posedge core_clk_in) #1;
    if (k == 900) begin
      miscompares++;
      finish_test();
    end
  endtask : do_op
  always @(posedge core_clk_in) begin
    if (page_data_take_out === 1'b1) begin
      #1;
      if (pg.size() > 0) page_data_in = pg.pop_front();
    end
  end
  always @(posedge ctl.we_n)
    if (ctl.ce_n === 1'b0) chk_wr(exp_wr.pop_front(), {ctl.addr, bus});
  always @(negedge core_clk_in) begin
    if (done_out === 1'b1 || refused_out === 1'b1)
      chk_val("result", exp_res.pop_front(), {refused_out, rdata_out});
    chk_val("oe_we_low", 17'h1, 17'(ctl.oe_n | ctl.we_n));
    chk_val("dq_drive", 17'h1, 17'(dq_oe_n_out | (~ctl.ce_n & ctl.oe_n)));
  end
  initial begin
    #400000;
    miscompares++;
    finish_test();
  end
  initial begin
    void'($urandom(32'hC7DE));
    repeat (16) @(posedge core_clk_in);
    #1;
    rst_n_in = 1'b1;
    do_op(OP_STATUS, 22'h000000, '0, '0, 1'b1);
    do_op(OP_CLR_STATUS, 22'h000000, '0, '0, 1'b0);
    do_op(OP_STATUS, 22'h000000, '0, '0, 1'b1);
    for (int i = 0; i < 16; i++) begin
      logic [21:0] a;
      a = (i == 14) ? '0 : {6'($urandom), 16'($urandom_range(2))};
      do_op(op_e'(i), a, 16'($urandom), 6'($urandom_range(3)), i < 4);
    end
    for (int c = 0; c < 8; c++) for (int p = 0; p < 4; p++) begin
      part_cfg_in = 3'(c);
      do_op(OP_READ_ID, {2'(p), 20'h00001}, '0, '0, 1'b1);
    end
    part_cfg_in = 3'h5;
    do_op(OP_PART_CFG, '0, 16'h0500, '0, 1'b0);
    do_op(OP_READ_ID, 22'h300006, '0, '0, 1'b1);
    do_op(OP_READ_ID, 22'h200006, '0, '0, 1'b1);
    do_op(OP_READ_ID, 22'h118002, '0, '0, 1'b1);
    do_op(OP_PAGE_PROG, 22'h040010, '0, 6'h07, 1'b0);
    supply_low_in = 1'b1;
    for (int j = 5; j < 16; j++)
      if (j inside {5, 6, 7, 8, 11, 12, 13, 14, 15})
        do_op(op_e'(j), 22'h050000, 16'h1234, '0, 1'b0);
    do_op(OP_READ_ARRAY, 22'h05ABCD, '0, '0, 1'b1);
    supply_low_in = 1'b0;
    finish_test();
  end
endmodule : tb
`default_nettype wire
